// file: rtl/config_word_fuse_decode.sv
// Operation
// RULE1 - fail-safe monitor enabled when its field set
// RULE2 - clock output field 1 keeps pin undriven
// RULE3 - one brown-out mode: on awake, off asleep
// RULE4 - another brown-out mode follows software enable bit
// RULE5 - reset select 0: pin is input, pullup register
// RULE6 - reset select 1: pin resets, pull-up on
// RULE7 - word sampled at reset, outputs held after
`timescale 1ns/10ps
`default_nettype none
module config_word_fuse_decode (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        reset_n_in,
    // avalon-mm slave
    input  wire logic [3:0]  address_in,
    input  wire logic        read_in,
    input  wire logic        write_in,
    input  wire logic [31:0] writedata_in,
    input  wire logic [3:0]  byteenable_in,
    output logic      [31:0] readdata_out,
    output logic             waitrequest_out,
    // pin and core state
    input  wire logic        external_reset_pin_in,
    input  wire logic        sleep_in,
    // decoded controls
    output logic             failsafe_monitor_enable_out,
    output logic             internal_external_switchover_out,
    output logic             clock_output_drive_out,
    output logic             brownout_enable_out,
    output logic             data_memory_protect_out,
    output logic             program_memory_protect_out,
    output logic             powerup_timer_enable_out,
    output logic [1:0]       watchdog_mode_out,
    output logic [2:0]       oscillator_select_out,
    // reset pin function
    output logic             external_reset_out,
    output logic             reset_pin_digital_out,
    output logic             reset_pin_pullup_out
);
    logic [13:0]                   config_word_q;
    logic [13:0]                   latched_word_q;
    logic                          sampled_q;
    logic                          software_brownout_enable_q;
    logic                          port_pullup_q;
    logic                          wait_q;
    logic [31:0]                   readdata_q;
    logic [31:0]                   read_value;
    logic [31:0]                   write_value;
    logic                          bus_write;
    logic                          pin_level;
    logic                          reset_pin_function_select;
    fuse_decode_pkg::bor_mode_t    bor_mode;
    pin_sync_if                    sync_bus ();

    // merges the written byte lanes over the old register contents
    function automatic logic [31:0] merge_lanes(input logic [31:0] old_word,
                                                input logic [31:0] new_word,
                                                input logic [3:0]  lanes);
        logic [31:0] result;
        result = old_word;
        for (int i = 0; i < 4; i++) begin
            if (lanes[i]) begin
                result[8*i +: 8] = new_word[8*i +: 8];
            end
        end
        return result;
    endfunction : merge_lanes

    // the pin arrives from outside the clock domain
    assign sync_bus.raw_level = external_reset_pin_in;

    pin_sync u_pin_sync (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .sync_bus   (sync_bus)
    );

    assign pin_level                 = sync_bus.clean_level;
    assign reset_pin_function_select = latched_word_q[fuse_decode_pkg::BIT_RESET_SEL];
    assign bor_mode = fuse_decode_pkg::bor_mode_t'({latched_word_q[fuse_decode_pkg::BIT_BOR_HI],
                                                   latched_word_q[fuse_decode_pkg::BIT_BOR_LO]});

    // read mux; unmapped offsets read as zero
    always_comb begin
        case (address_in)
            fuse_decode_pkg::OFF_CONFIG: read_value = {18'h0, config_word_q};
            fuse_decode_pkg::OFF_POWER:  read_value = {31'h0, software_brownout_enable_q};
            fuse_decode_pkg::OFF_PULLUP: read_value = {31'h0, port_pullup_q};
            fuse_decode_pkg::OFF_STATUS: read_value = {14'h0, sampled_q, pin_level, 2'h0,
                                                       latched_word_q};
            default:                     read_value = 32'h0;
        endcase
    end

    assign write_value = merge_lanes(read_value, writedata_in, byteenable_in);
    assign bus_write   = write_in && !wait_q;

    // one wait cycle per access; writes land on the edge after release, where waitrequest rises again
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wait_q <= fuse_decode_pkg::WAIT_RESET;
        end else if (!wait_q) begin
            wait_q <= 1'h1;
        end else if (read_in || write_in) begin
            wait_q <= 1'h0;
        end
    end

    // read data is captured on the edge that drops waitrequest and held until the next read
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            readdata_q <= 32'h0;
        end else if (read_in && wait_q) begin
            readdata_q <= read_value;
        end
    end

    // stored word; writes only take effect at the next sampling
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            config_word_q <= fuse_decode_pkg::FUSE_ERASED;
        end else if (bus_write && address_in == fuse_decode_pkg::OFF_CONFIG) begin
            config_word_q <= write_value[13:0];
        end
    end

    // software brown-out enable and port pull-up bits
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            software_brownout_enable_q <= fuse_decode_pkg::SW_BOR_RESET;
            port_pullup_q              <= fuse_decode_pkg::PULLUP_RESET;
        end else if (bus_write) begin
            if (address_in == fuse_decode_pkg::OFF_POWER) begin
                software_brownout_enable_q <= write_value[0];
            end
            if (address_in == fuse_decode_pkg::OFF_PULLUP) begin
                port_pullup_q <= write_value[0];
            end
        end
    end

    // sample once after power-on or pin reset, then freeze
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sampled_q      <= 1'h0;
            latched_word_q <= fuse_decode_pkg::FUSE_ERASED;
        end else if (external_reset_out) begin
            sampled_q <= 1'h0;  // see RULE7
        end else if (!sampled_q) begin
            sampled_q      <= 1'h1;
            latched_word_q <= config_word_q;  // see RULE7
        end
    end

    // decoded outputs; protect and power-up timer fields are active low in the word
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            failsafe_monitor_enable_out      <= 1'h0;
            internal_external_switchover_out <= 1'h0;
            clock_output_drive_out           <= 1'h0;
            data_memory_protect_out          <= 1'h0;
            program_memory_protect_out       <= 1'h0;
            powerup_timer_enable_out         <= 1'h0;
            watchdog_mode_out                <= 2'h0;
            oscillator_select_out            <= 3'h0;
        end else begin
            failsafe_monitor_enable_out <=
                latched_word_q[fuse_decode_pkg::BIT_FAILSAFE];  // see RULE1
            internal_external_switchover_out <= latched_word_q[fuse_decode_pkg::BIT_SWITCHOVER];
            clock_output_drive_out <= !latched_word_q[fuse_decode_pkg::BIT_CLKOUT];  // see RULE2
            data_memory_protect_out    <= !latched_word_q[fuse_decode_pkg::BIT_DATA_PROT];
            program_memory_protect_out <= !latched_word_q[fuse_decode_pkg::BIT_PROG_PROT];
            powerup_timer_enable_out   <= !latched_word_q[fuse_decode_pkg::BIT_PWRUP];
            watchdog_mode_out <=
                latched_word_q[fuse_decode_pkg::BIT_WDT_HI:fuse_decode_pkg::BIT_WDT_LO];
            oscillator_select_out <=
                latched_word_q[fuse_decode_pkg::BIT_OSC_HI:fuse_decode_pkg::BIT_OSC_LO];
        end
    end

    // brown-out detector enable by mode
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            brownout_enable_out <= 1'h0;
        end else begin
            case (bor_mode)
                fuse_decode_pkg::BOR_ON:         brownout_enable_out <= 1'h1;
                fuse_decode_pkg::BOR_AWAKE_ONLY: brownout_enable_out <= !sleep_in;  // see RULE3
                fuse_decode_pkg::BOR_SOFTWARE:
                    brownout_enable_out <= software_brownout_enable_q;  // see RULE4
                default:                         brownout_enable_out <= 1'h0;
            endcase
        end
    end

    // reset pin: low level resets only when selected; pull-up follows the mode
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            external_reset_out    <= 1'h0;
            reset_pin_digital_out <= 1'h0;
            reset_pin_pullup_out  <= 1'h0;
        end else if (reset_pin_function_select) begin
            external_reset_out    <= !pin_level;  // see RULE6
            reset_pin_digital_out <= 1'h0;
            reset_pin_pullup_out  <= 1'h1;  // see RULE6
        end else begin
            external_reset_out    <= 1'h0;  // see RULE5
            reset_pin_digital_out <= pin_level;  // see RULE5
            reset_pin_pullup_out  <= port_pullup_q;  // see RULE5
        end
    end

    assign readdata_out    = readdata_q;
    assign waitrequest_out = wait_q;

    // checks on the decode
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);

    sequence s_pin_reset_release;
        external_reset_out ##1 !external_reset_out;
    endsequence

    sequence s_bus_access;
        (read_in || write_in) && waitrequest_out ##1 !waitrequest_out;
    endsequence

    chk_failsafe_follows_word: assert property ( // see RULE1
        sampled_q |=> failsafe_monitor_enable_out == $past(latched_word_q[13]))
        else $error("fail-safe enable does not follow the sampled word");
    chk_clkout_gate: assert property ( // see RULE2
        sampled_q |=> clock_output_drive_out == !$past(latched_word_q[11]))
        else $error("clock output drive wrong for its field");
    chk_bor_sleep_mode: assert property ( // see RULE3
        bor_mode == fuse_decode_pkg::BOR_AWAKE_ONLY |=> brownout_enable_out == !$past(sleep_in))
        else $error("brown-out not off in sleep or not on while awake");
    chk_bor_software_mode: assert property ( // see RULE4
        bor_mode == fuse_decode_pkg::BOR_SOFTWARE
            |=> brownout_enable_out == $past(software_brownout_enable_q))
        else $error("brown-out enable ignores the software bit");
    chk_pin_digital_input: assert property ( // see RULE5
        !reset_pin_function_select |=> !external_reset_out
            && reset_pin_pullup_out == $past(port_pullup_q)
            && reset_pin_digital_out == $past(pin_level))
        else $error("reset pin not a plain input with register pull-up");
    chk_pin_reset_function: assert property ( // see RULE6
        reset_pin_function_select && !pin_level |=> external_reset_out && reset_pin_pullup_out)
        else $error("low reset pin did not reset or pull-up off");
    chk_word_hold: assert property ( // see RULE7
        sampled_q && $past(sampled_q) |-> $stable(latched_word_q))
        else $error("sampled word changed before a reset");
    chk_resample_after_reset: assert property ( // see RULE7
        s_pin_reset_release |=> sampled_q && latched_word_q == $past(config_word_q))
        else $error("word not resampled after pin reset release");
    chk_bus_answer: assert property (
        s_bus_access |=> waitrequest_out)
        else $error("waitrequest low for more than one cycle");
endmodule : config_word_fuse_decode
`default_nettype wire

// file: rtl/fuse_decode_pkg.sv
package fuse_decode_pkg;
    // configuration word layout, erased (unprogrammed) value is all ones
    localparam int unsigned WORD_W      = 14;
    localparam logic [13:0] FUSE_ERASED = 14'h3FFF;
    localparam int BIT_FAILSAFE   = 13;
    localparam int BIT_SWITCHOVER = 12;
    localparam int BIT_CLKOUT     = 11;
    localparam int BIT_BOR_HI     = 10;
    localparam int BIT_BOR_LO     = 9;
    localparam int BIT_DATA_PROT  = 8;
    localparam int BIT_PROG_PROT  = 7;
    localparam int BIT_RESET_SEL  = 6;
    localparam int BIT_PWRUP      = 5;
    localparam int BIT_WDT_HI     = 4;
    localparam int BIT_WDT_LO     = 3;
    localparam int BIT_OSC_HI     = 2;
    localparam int BIT_OSC_LO     = 0;

    // register byte offsets
    localparam logic [3:0] OFF_CONFIG = 4'h0;
    localparam logic [3:0] OFF_POWER  = 4'h4;
    localparam logic [3:0] OFF_PULLUP = 4'h8;
    localparam logic [3:0] OFF_STATUS = 4'hC;

    // status register fields above the sampled word
    localparam int ST_PIN     = 16;
    localparam int ST_SAMPLED = 17;

    // values after reset
    localparam logic SW_BOR_RESET = 1'h1;
    localparam logic PULLUP_RESET = 1'h1;
    localparam logic PIN_IDLE     = 1'h1;
    localparam logic WAIT_RESET   = 1'h1;

    // brown-out reset modes, {high, low}
    typedef enum logic [1:0] {
        BOR_OFF        = 2'b00,
        BOR_SOFTWARE   = 2'b01,
        BOR_AWAKE_ONLY = 2'b10,
        BOR_ON         = 2'b11
    } bor_mode_t;
endpackage : fuse_decode_pkg

// file: rtl/pin_sync_if.sv
`timescale 1ns/10ps
`default_nettype none
interface pin_sync_if;
    logic raw_level;
    logic clean_level;
    modport filter (input raw_level, output clean_level);
    modport user (output raw_level, input clean_level);
endinterface : pin_sync_if
`default_nettype wire

// file: rtl/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
    // clock and reset
    input  wire logic   clk_in,
    input  wire logic   reset_n_in,
    // pin level in, settled level out
    pin_sync_if.filter  sync_bus
);
    logic stage1_q;
    logic stage2_q;
    logic stage3_q;
    logic level_q;

    // three-flop chain; stage1 feeds only stage2 to keep metastability contained
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            stage1_q <= fuse_decode_pkg::PIN_IDLE;
            stage2_q <= fuse_decode_pkg::PIN_IDLE;
            stage3_q <= fuse_decode_pkg::PIN_IDLE;
        end else begin
            stage1_q <= sync_bus.raw_level;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
        end
    end

    // a change counts only once the two later stages agree
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            level_q <= fuse_decode_pkg::PIN_IDLE;
        end else if (stage2_q == stage3_q) begin
            level_q <= stage3_q;
        end
    end

    assign sync_bus.clean_level = level_q;
endmodule : pin_sync
`default_nettype wire

// file: tb/config_word_fuse_decode_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_fail++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module config_word_fuse_decode_tb;
    logic        clk_in = 1'b0;
    logic        reset_n_in = 1'b0;
    logic [3:0]  address_in = 4'h0;
    logic        read_in = 1'b0;
    logic        write_in = 1'b0;
    logic [31:0] writedata_in = 32'h0;
    logic [3:0]  byteenable_in = 4'hF;
    wire  [31:0] readdata_out;
    wire         waitrequest_out;
    wire  [14:0] outs;
    logic        pin = 1'b1;
    logic        sleep = 1'b0;
    logic        snap_q = 1'b0;
    logic [31:0] rd_q[$];
    logic [14:0] out_q[$];
    logic [31:0] rd_exp;
    logic [14:0] out_exp;
    logic [31:0] d;
    logic [13:0] w;
    logic [13:0] cur = fuse_decode_pkg::FUSE_ERASED; // word the decode should be using
    logic        sw = fuse_decode_pkg::SW_BOR_RESET;
    logic        pu = fuse_decode_pkg::PULLUP_RESET;
    int          n_fail = 0;
    int          comparisons = 0;
    int          seed = 64239;

    config_word_fuse_decode dut (
        .clk_in                           (clk_in),
        .reset_n_in                       (reset_n_in),
        .address_in                       (address_in),
        .read_in                          (read_in),
        .write_in                         (write_in),
        .writedata_in                     (writedata_in),
        .byteenable_in                    (byteenable_in),
        .readdata_out                     (readdata_out),
        .waitrequest_out                  (waitrequest_out),
        .external_reset_pin_in            (pin),
        .sleep_in                         (sleep),
        .failsafe_monitor_enable_out      (outs[14]),
        .internal_external_switchover_out (outs[13]),
        .clock_output_drive_out           (outs[12]),
        .brownout_enable_out              (outs[11]),
        .data_memory_protect_out          (outs[10]),
        .program_memory_protect_out       (outs[9]),
        .powerup_timer_enable_out         (outs[8]),
        .watchdog_mode_out                (outs[7:6]),
        .oscillator_select_out            (outs[5:3]),
        .external_reset_out               (outs[2]),
        .reset_pin_digital_out            (outs[1]),
        .reset_pin_pullup_out             (outs[0])
    );

    // 200 MHz clock
    always #2.5 clk_in = ~clk_in;

    // decoded outputs expected from a sampled word and the live inputs
    function automatic logic [14:0] expect_out(input logic [13:0] v, input logic s,
                                               input logic b, input logic p, input logic x);
        logic bor;
        case (v[10:9])
            2'b11:   bor = 1'b1;
            2'b10:   bor = ~s;
            2'b01:   bor = b;
            default: bor = 1'b0;
        endcase
        return {v[13], v[12], ~v[11], bor, ~v[8], ~v[7], ~v[5], v[4:3], v[2:0],
                v[6] & ~x, v[6] ? 1'b0 : x, v[6] ? 1'b1 : p};
    endfunction : expect_out

    // wait for the slave to drop waitrequest; only the watchdog ends a hang
    task automatic wait_ack();
        do begin
            @(posedge clk_in);
        end while (waitrequest_out !== 1'b0);
    endtask : wait_ack

    // one edge idle after release so a strobe is never reassigned in one step
    task automatic bus_write(input logic [3:0] a, input logic [31:0] v);
        address_in <= a;
        writedata_in <= v;
        write_in <= 1'b1;
        wait_ack();
        write_in <= 1'b0;
        @(posedge clk_in);
    endtask : bus_write

    task automatic bus_read(input logic [3:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        address_in <= a;
        read_in <= 1'b1;
        wait_ack();
        read_in <= 1'b0;
        @(posedge clk_in);
    endtask : bus_read

    task automatic snap();
        out_q.push_back(expect_out(cur, sleep, sw, pu, pin));
        snap_q <= 1'b1;
        @(posedge clk_in);
        snap_q <= 1'b0;
        @(posedge clk_in);
    endtask : snap

    // pull the pin low until the reset shows, then let the word resample
    task automatic pin_reset(input logic [13:0] v);
        int n;
        n = 0;
        pin <= 1'b0;
        do begin
            @(posedge clk_in);
            n++;
        end while (outs[2] !== 1'b1 && n < 20);
        if (n >= 20) n_fail++;
        pin <= 1'b1;
        repeat (10) @(posedge clk_in);
        cur = v;
    endtask : pin_reset

    task automatic final_report();
        if (n_fail == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    // monitor: oldest note against each result as it appears
    always @(posedge clk_in) begin
        if (read_in === 1'b1 && waitrequest_out === 1'b0) begin
            if (rd_q.size() == 0) n_fail++;
            rd_exp = rd_q.pop_front();
            `CHECK(readdata_out, rd_exp)
        end
        if (snap_q === 1'b1) begin
            out_exp = out_q.pop_front();
            `CHECK(outs, out_exp)
        end
    end

    // watchdog: the whole sequence needs well under this many cycles
    initial begin
        repeat (20000) @(posedge clk_in);
        n_fail++;
        final_report();
    end

    initial begin
        repeat (6) @(posedge clk_in);
        reset_n_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        snap();
        bus_read(fuse_decode_pkg::OFF_STATUS, {14'h0, 2'b11, 2'b00, cur});
        bus_write(fuse_decode_pkg::OFF_STATUS, 32'h0); // read-only place
        bus_read(fuse_decode_pkg::OFF_STATUS, {14'h0, 2'b11, 2'b00, cur});
        bus_read(4'h1, 32'h0);
        // every brown-out mode with every sleep and software bit pairing
        for (int m = 0; m < 4; m++) begin
            d = $random(seed);
            w = d[13:0];
            w[10:9] = m[1:0];
            w[6] = 1'b1;
            d[13:0] = w;
            bus_write(fuse_decode_pkg::OFF_CONFIG, d);
            bus_read(fuse_decode_pkg::OFF_CONFIG, {18'h0, w});
            snap(); // stored word not yet in use
            pin_reset(w);
            for (int k = 0; k < 4; k++) begin
                sw = k[0];
                sleep <= k[1];
                bus_write(fuse_decode_pkg::OFF_POWER, {31'h0, sw});
                repeat (3) @(posedge clk_in);
                snap();
            end
        end
        sleep <= 1'b0;
        // reset pin as a plain input with pull-up from the port register
        d = $random(seed);
        w = d[13:0];
        w[6] = 1'b0;
        d[13:0] = w;
        bus_write(fuse_decode_pkg::OFF_CONFIG, d);
        pin_reset(w);
        for (int k = 0; k < 4; k++) begin
            pu = k[0];
            pin <= k[1];
            bus_write(fuse_decode_pkg::OFF_PULLUP, {31'h0, pu});
            repeat (6) @(posedge clk_in);
            snap();
            bus_read(fuse_decode_pkg::OFF_STATUS, {14'h0, 1'b1, pin, 2'b00, cur});
        end
        // only lane one written: upper config bits clear, low byte stays
        byteenable_in <= 4'h2;
        bus_write(fuse_decode_pkg::OFF_CONFIG, 32'h0);
        byteenable_in <= 4'hF;
        bus_read(fuse_decode_pkg::OFF_CONFIG, {18'h0, 6'h0, w[7:0]});
        bus_read(fuse_decode_pkg::OFF_POWER, {31'h0, sw});
        bus_read(fuse_decode_pkg::OFF_PULLUP, {31'h0, pu});
        final_report();
    end
endmodule : config_word_fuse_decode_tb
`default_nettype wire
